/* hw/rivp_pkg.sv */
package rivp_pkg;

	localparam int unsigned NUM_SRC = 25;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned PADDR_W = 12;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] MASK_OFS = 12'h008;
	localparam logic [11:0] VECTOR_OFS = 12'h00C;

	// Control fields
	localparam int unsigned CTRL_SEL_BIT = 0;
	localparam int unsigned CTRL_WIDE_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [24:0] STATUS_RST = 25'h0000000;
	localparam logic [24:0] MASK_RST = 25'h0000000;

	// Vector placement
	localparam logic [15:0] RESET_VEC = 16'h0000;
	localparam logic [15:0] BOOT_START_NARROW = 16'h0C00;
	localparam logic [15:0] BOOT_START_WIDE = 16'h1C00;
	localparam logic FUSE_UNPROGRAMMED = 1'b1;

	typedef enum logic [2:0] {
		RIVP_ST_RESET = 3'b001,
		RIVP_ST_IDLE  = 3'b010,
		RIVP_ST_OFFER = 3'b100
	} rivp_state_e;

endpackage

/* hw/rivp_vector_gen.sv */
// Behaviour
// (R1) Every reset cause fetches 0x0000 when unprogrammed
// (R2) Wide layout: sources two words apart from 0x0002
// (R3) Timer vectors 0x000E to 0x0020 in order
// (R4) Remaining vectors to 0x0032, 26 in total
// (R5) Programmed fuse resets to boot loader start
// (R6) Table select adds boot start to offsets
// (R7) Narrow layout: boot 0xC00, handlers 0xC01-0xC19
// (R8) Software sets table select before enabling sources
// (R9) Vector offered only for a taken interrupt
// (R10) Fuse 1 unprogrammed, 0 programmed
// (R11) Lowest pending vector number wins
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rivp_vector_gen
(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  boot_reset_fuse,
	input  wire logic                  core_int_enable,
	input  wire logic [24:0]           irq_src,
	output logic                       vector_valid,
	output logic                       vector_is_reset,
	output logic      [15:0]           vector_addr,
	input  wire logic                  vector_ack,
	output logic                       irq
);

	logic        [1:0]  ctrl_r;
	logic        [24:0] status_r;
	logic        [24:0] mask_r;
	logic        [15:0] last_vec_r;
	logic        [31:0] prdata_r;
	logic               fuse_r;
	logic        [4:0]  idx_r;
	logic        [15:0] addr_r;
	rivp_pkg::rivp_state_e state_r;

	logic               setup_ph;
	logic               wr_en;
	logic               mapped;
	logic        [24:0] eligible;
	logic        [24:0] w1c;
	logic        [24:0] taken;
	logic        [4:0]  win_idx;
	logic               win_any;
	logic        [15:0] boot_start;
	logic        [15:0] reset_addr;
	logic        [15:0] win_addr;

	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign mapped = (paddr == rivp_pkg::CTRL_OFS)
		|| (paddr == rivp_pkg::STATUS_OFS)
		|| (paddr == rivp_pkg::MASK_OFS)
		|| (paddr == rivp_pkg::VECTOR_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;

	// Only sources software enabled and the core accepts may be fetched
	assign eligible = status_r & mask_r & {25{core_int_enable}}; // R9
	assign irq = |(status_r & mask_r);

	always_comb
	begin
		win_idx = 5'h00;
		win_any = 1'b0;
		for (int i = rivp_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (eligible[i])
			begin
				win_idx = i[4:0]; // R11
				win_any = 1'b1;
			end
		end
	end

	// Wide parts place the boot section higher than narrow ones
	assign boot_start = ctrl_r[rivp_pkg::CTRL_WIDE_BIT]
		? rivp_pkg::BOOT_START_WIDE : rivp_pkg::BOOT_START_NARROW; // R7

	assign reset_addr = (fuse_r == rivp_pkg::FUSE_UNPROGRAMMED)
		? rivp_pkg::RESET_VEC : boot_start; // R1 R5 R10

	always_comb
	begin
		logic [15:0] ofs;
		ofs = 16'h0000;
		ofs = {11'h000, win_idx} + 16'h0001; // R7
		if (ctrl_r[rivp_pkg::CTRL_WIDE_BIT])
			ofs = {ofs[14:0], 1'b0}; // R2 R3 R4
		if (ctrl_r[rivp_pkg::CTRL_SEL_BIT])
			win_addr = boot_start + ofs; // R6
		else
			win_addr = ofs;
	end

	// Fuse is a strap: caught while reset holds, kept after release
	always_ff @(posedge clock)
	begin
		if (srst)
			fuse_r <= boot_reset_fuse; // R10
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			ctrl_r <= rivp_pkg::CTRL_RST;
		else if (wr_en && paddr == rivp_pkg::CTRL_OFS)
			ctrl_r <= pwdata[1:0];
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			mask_r <= rivp_pkg::MASK_RST;
		else if (wr_en && paddr == rivp_pkg::MASK_OFS)
			mask_r <= pwdata[24:0];
	end

	assign w1c = (wr_en && paddr == rivp_pkg::STATUS_OFS)
		? pwdata[24:0] : 25'h0000000;
	assign taken = (state_r == rivp_pkg::RIVP_ST_OFFER && vector_ack
		&& eligible[idx_r]) ? (25'h0000001 << idx_r) : 25'h0000000;

	// New events win over a clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (srst)
			status_r <= rivp_pkg::STATUS_RST;
		else
			status_r <= (status_r & ~(w1c | taken)) | irq_src;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			prdata_r <= 32'h00000000;
		else if (setup_ph && !pwrite)
		begin
			unique case (paddr)
				rivp_pkg::CTRL_OFS:   prdata_r <= {30'h00000000, ctrl_r};
				rivp_pkg::STATUS_OFS: prdata_r <= {7'h00, status_r};
				rivp_pkg::MASK_OFS:   prdata_r <= {7'h00, mask_r};
				rivp_pkg::VECTOR_OFS: prdata_r <= {16'h0000, last_vec_r};
				default:              prdata_r <= 32'h00000000;
			endcase
		end
	end

	// Reset vector offered first, then interrupts one at a time
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r <= rivp_pkg::RIVP_ST_RESET;
			idx_r <= 5'h00;
			addr_r <= 16'h0000;
			last_vec_r <= 16'h0000;
		end
		else
		begin
			unique case (state_r)
				rivp_pkg::RIVP_ST_RESET:
				begin
					addr_r <= reset_addr; // R1 R5
					if (vector_ack)
					begin
						last_vec_r <= reset_addr;
						state_r <= rivp_pkg::RIVP_ST_IDLE;
					end
				end
				rivp_pkg::RIVP_ST_IDLE:
				begin
					if (win_any)
					begin
						idx_r <= win_idx; // R11
						addr_r <= win_addr;
						state_r <= rivp_pkg::RIVP_ST_OFFER;
					end
				end
				rivp_pkg::RIVP_ST_OFFER:
				begin
					// Withdrawn if software cleared or masked it meanwhile
					if (!eligible[idx_r] || vector_ack)
						state_r <= rivp_pkg::RIVP_ST_IDLE; // R9
					if (eligible[idx_r] && vector_ack)
						last_vec_r <= addr_r;
				end
			endcase
		end
	end

	assign vector_is_reset = (state_r == rivp_pkg::RIVP_ST_RESET);
	assign vector_valid = vector_is_reset
		|| (state_r == rivp_pkg::RIVP_ST_OFFER && eligible[idx_r]); // R9
	assign vector_addr = vector_is_reset ? reset_addr : addr_r;

	// Helper for assertion checks
	logic [15:0] exp_ofs;
	assign exp_ofs = ctrl_r[rivp_pkg::CTRL_WIDE_BIT]
		? {10'h000, idx_r, 1'b0} + 16'h0002
		: {11'h000, idx_r} + 16'h0001;

	reset_unprog_a: assert property (@(posedge clock) disable iff (srst) // R1
		vector_is_reset && fuse_r |-> vector_addr == 16'h0000)
		else $error("reset vector not at zero");

	reset_prog_a: assert property (@(posedge clock) disable iff (srst) // R5
		vector_is_reset && !fuse_r |-> vector_addr == boot_start)
		else $error("reset vector not at boot start");

	wide_last_a: assert property (@(posedge clock) disable iff (srst) // R4
		vector_valid && !vector_is_reset && idx_r == 5'h18
		&& ctrl_r == 2'h2 |-> vector_addr == 16'h0032)
		else $error("last wide vector misplaced");

	wide_timer_a: assert property (@(posedge clock) disable iff (srst) // R3
		vector_valid && !vector_is_reset && idx_r == 5'h06
		&& ctrl_r == 2'h2 |-> vector_addr == 16'h000E)
		else $error("first timer vector misplaced");

	wide_offset_a: assert property (@(posedge clock) disable iff (srst) // R2
		vector_valid && !vector_is_reset && ctrl_r == 2'h2
		|-> vector_addr == exp_ofs)
		else $error("wide vector offset wrong");

	narrow_boot_a: assert property (@(posedge clock) disable iff (srst) // R7
		vector_valid && !vector_is_reset && ctrl_r == 2'h1
		|-> vector_addr >= 16'h0C01 && vector_addr <= 16'h0C19)
		else $error("relocated narrow vector out of range");

	relocate_a: assert property (@(posedge clock) disable iff (srst) // R6
		vector_valid && !vector_is_reset && ctrl_r[0]
		|-> vector_addr == boot_start + exp_ofs)
		else $error("relocation base not added");

	// A take must retire its source, or the core would fetch it twice
	fetch_only_a: assert property (@(posedge clock) disable iff (srst) // R9
		vector_valid && !vector_is_reset && vector_ack
		&& !irq_src[idx_r] |=> !status_r[$past(idx_r)])
		else $error("taken source still pending");

	no_offer_a: assert property (@(posedge clock) disable iff (srst) // R9
		!core_int_enable |-> !vector_valid || vector_is_reset)
		else $error("vector offered while core disabled");

	vec_log_a: assert property (@(posedge clock) disable iff (srst) // R9
		!(vector_valid && vector_ack) |=> $stable(last_vec_r))
		else $error("vector log moved without a fetch");

	fuse_hold_a: assert property (@(posedge clock) disable iff (srst) // R10
		$fell(srst) |-> fuse_r == $past(boot_reset_fuse))
		else $error("fuse value not caught at reset");

	reset_first_a: assert property (@(posedge clock) disable iff (srst) // R1
		$fell(srst) |-> vector_valid && vector_is_reset)
		else $error("reset vector not offered after reset");

	reset_hold_a: assert property (@(posedge clock) disable iff (srst) // R5
		vector_is_reset && !vector_ack |=> vector_is_reset)
		else $error("reset vector withdrawn before fetch");

	lowest_win_a: assert property (@(posedge clock) disable iff (srst) // R11
		state_r == rivp_pkg::RIVP_ST_IDLE && win_any
		|=> idx_r == $past(win_idx)
		&& ($past(eligible) & ((25'h0000001 << idx_r) - 25'h0000001))
		== 25'h0000000)
		else $error("higher vector chosen over lower");

	set_wins_a: assert property (@(posedge clock) disable iff (srst)
		irq_src[0] |=> status_r[0])
		else $error("event lost against clear");

	narrow_ofs_a: assert property (@(posedge clock) disable iff (srst) // R7
		vector_valid && !vector_is_reset && ctrl_r == 2'h0
		|-> vector_addr == 16'h0001 + {11'h000, idx_r})
		else $error("narrow vector offset wrong");

	offer_stay_a: assert property (@(posedge clock) disable iff (srst)
		vector_valid && !vector_is_reset && !vector_ack
		|=> state_r == rivp_pkg::RIVP_ST_OFFER && $stable(addr_r))
		else $error("offer moved before fetch");

	w1c_clear_a: assert property (@(posedge clock) disable iff (srst)
		|(w1c & ~irq_src)
		|=> (status_r & $past(w1c) & ~$past(irq_src)) == 25'h0000000)
		else $error("status bit survived a clear");

	unmapped_a: assert property (@(posedge clock) disable iff (srst)
		psel && penable && !pwrite && !mapped
		|-> pslverr && prdata == 32'h00000000)
		else $error("unmapped read not refused");

	reset_fetch_c: cover property (@(posedge clock) disable iff (srst)
		vector_is_reset && vector_ack);
	relocated_c: cover property (@(posedge clock) disable iff (srst)
		vector_valid && !vector_is_reset && ctrl_r[0] && vector_ack);
	contend_c: cover property (@(posedge clock) disable iff (srst)
		win_any && $countones(eligible) > 1);
	narrow_c: cover property (@(posedge clock) disable iff (srst)
		vector_valid && !vector_is_reset && ctrl_r == 2'h0
		&& vector_ack);
	boot_reset_c: cover property (@(posedge clock) disable iff (srst)
		vector_is_reset && !fuse_r && vector_ack);

endmodule
`default_nettype wire

/* dv/rivp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rivp_core_model
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        vector_valid,
	input  wire logic [15:0] vector_addr,
	input  wire logic [3:0]  delay,
	output logic             vector_ack,
	output logic             taken,
	output logic      [15:0] taken_addr
);
	logic [3:0] cnt;

	// Waits delay cycles into an offer so slow fetches are exercised too
	always_ff @(posedge clock)
	begin
		taken <= 1'h0;
		if (srst)
		begin
			cnt <= 4'h0;
			vector_ack <= 1'h0;
		end
		else if (vector_valid && vector_ack)
		begin
			cnt <= 4'h0;
			vector_ack <= 1'h0;
			taken <= 1'h1;
			taken_addr <= vector_addr;
		end
		else if (!vector_valid)
		begin
			cnt <= 4'h0;
			vector_ack <= 1'h0;
		end
		else if (cnt >= delay)
			vector_ack <= 1'h1;
		else
			cnt <= cnt + 4'h1;
	end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
	logic        clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
	logic        pwrite = 1'h0, fuse = 1'h1, en = 1'h0, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, vector_valid, vector_is_reset, irq;
	logic        vector_ack, taken;
	logic [24:0] irq_src = 25'h0;
	logic [15:0] vector_addr, taken_addr;
	logic [3:0]  delay = 4'h0;
	int          bad_count = 0, comparisons = 0;

	always #5 clock = ~clock;

	rivp_vector_gen rivp_vector_gen_i (.clock(clock), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .boot_reset_fuse(fuse), .core_int_enable(en),
		.irq_src(irq_src), .vector_valid(vector_valid),
		.vector_is_reset(vector_is_reset), .vector_addr(vector_addr),
		.vector_ack(vector_ack), .irq(irq));
	rivp_core_model rivp_core_model_i (.clock(clock), .srst(srst),
		.vector_valid(vector_valid), .vector_addr(vector_addr),
		.delay(delay), .vector_ack(vector_ack), .taken(taken),
		.taken_addr(taken_addr));

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1)
			@(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge so a following call never drives psel twice at once
		@(posedge clock);
	endtask

	// Bounded wait for the core to take an offer
	task take(input logic [15:0] exp);
		int n;
		n = 0;
		@(posedge clock);
		while (taken !== 1'h1 && n < 50)
		begin
			@(posedge clock);
			n++;
		end
		`CHK({taken, taken_addr}, {1'h1, exp})
	endtask

	task fire(input logic [24:0] bits);
		irq_src <= bits;
		@(posedge clock);
		irq_src <= 25'h0;
	endtask

	task do_reset(input logic f, input logic [15:0] exp);
		srst <= 1'h1;
		fuse <= f;
		en <= 1'h0;
		repeat (5) @(posedge clock);
		srst <= 1'h0;
		@(posedge clock);
		`CHK({vector_valid, vector_is_reset}, 2'h3)
		take(exp);
		apb(1'h0, rivp_pkg::CTRL_OFS, 32'h0);
		`CHK(rd, 32'h2)
	endtask

	task s_table;
		apb(1'h1, rivp_pkg::MASK_OFS, 32'h01FFFFFF);
		en <= 1'h1;
		for (int i = 0; i < 25; i++)
		begin
			delay <= 4'(i % 4);
			fire(25'h1 << i);
			take(16'(2 * (i + 1)));
			apb(1'h0, rivp_pkg::VECTOR_OFS, 32'h0);
			`CHK(rd, 32'(2 * (i + 1)))
		end
	endtask

	task s_reloc;
		en <= 1'h0;
		apb(1'h1, rivp_pkg::CTRL_OFS, 32'h1);
		en <= 1'h1;
		fire(25'h1);
		take(16'h0C01);
		fire(25'h1000000);
		take(16'h0C19);
		apb(1'h1, rivp_pkg::CTRL_OFS, 32'h3);
		fire(25'h1000000);
		take(16'h1C32);
		apb(1'h1, rivp_pkg::CTRL_OFS, 32'h0);
		fire(25'h1000000);
		take(16'h0019);
		apb(1'h1, rivp_pkg::CTRL_OFS, 32'h2);
	endtask

	task s_prio;
		en <= 1'h0;
		fire(25'h88);
		en <= 1'h1;
		take(16'h0008);
		take(16'h0010);
	endtask

	task s_mask;
		apb(1'h1, rivp_pkg::MASK_OFS, 32'h01FFFFF7);
		fire(25'h8);
		repeat (4) @(posedge clock);
		`CHK({irq, vector_valid}, 2'h0)
		apb(1'h0, rivp_pkg::STATUS_OFS, 32'h0);
		`CHK(rd, 32'h8)
		apb(1'h1, rivp_pkg::STATUS_OFS, 32'h8);
		apb(1'h0, rivp_pkg::STATUS_OFS, 32'h0);
		`CHK(rd, 32'h0)
		en <= 1'h0;
		fire(25'h20);
		repeat (4) @(posedge clock);
		`CHK({irq, vector_valid}, 2'h2)
		en <= 1'h1;
		take(16'h000C);
		apb(1'h0, 12'h010, 32'h0);
		`CHK({er, rd}, {1'h1, 32'h0})
	endtask

	task end_sim;
		$display("Mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		do_reset(1'h1, 16'h0000);
		do_reset(1'h0, 16'h1C00);
		do_reset(1'h1, 16'h0000);
		s_table;
		s_reloc;
		s_prio;
		s_mask;
		end_sim;
	end

	// Whole run needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_sim;
	end
endmodule
`default_nettype wire
